/* design/fps_top.sv */
// Purpose: fan channel source select, manual duty and polarity, APB regs
// Assumes: source duties arrive from on-clock logic, no synchroniser
// Notes:   zero-wait APB slave, read data registered in the setup cycle
//
// Notes on behaviour
// - channel alternative bit 3 set selects the alternative mapping.
// - polarity bit 4 clear gives high output at full duty, set inverts.
// - behaviour field bits 7:5 picks source or mode through the mapping.
// - default codes 0,1,2 follow remote 1, local and remote 2 duties.
// - default code 3 runs full speed and is the field's reset value.
// - default code 4 disables the fan drive.
// - default code 5 takes the larger of local and remote 2 duties.
// - default code 6 takes the largest of the three analog duties.
// - default code 7 is manual: duty regs 0x30-0x32 writable and used.
// - alternative codes 0..3 follow cpu thermal readings 0..3.
// - alternative codes 4 and 6 run the fan at full duty.
// - alternative code 5 takes the largest of the four cpu duties.
// - alternative code 7 takes the largest of all seven zone duties.
// - lock bit in reg 0x40 makes channel config regs ignore writes.
// - replace bit 4 of reg 0x36 forces channel 1 to alternative mapping.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fps_top (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire fps_pkg::fps_apb_req_t  apb_req,
	output fps_pkg::fps_apb_rsp_t       apb_rsp,
	input  wire fps_pkg::fps_src_t      src_duty,
	output logic [fps_pkg::NUM_CH-1:0]  fan_pwm
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [fps_pkg::NUM_CH-1:0][7:0] chcfg;
		logic [fps_pkg::NUM_CH-1:0][7:0] man_duty;
		logic [fps_pkg::NUM_CH-1:0][7:0] applied;
		logic [7:0]                      cfg1;
		logic [7:0]                      cfg6;
		logic [fps_pkg::DATA_W-1:0]      rdata;
		logic                            rerr;
	} fps_state_t;

	fps_state_t st_reg;
	fps_state_t st_next;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [7:0] max2(
		input logic [7:0] a,
		input logic [7:0] b
	);
		max2 = (a > b) ? a : b;
	endfunction

	function automatic logic [7:0] max4(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c,
		input logic [7:0] d
	);
		max4 = max2(max2(a, b), max2(c, d));
	endfunction

	// duty chosen for a channel from its behaviour code and mapping
	function automatic logic [7:0] pick_duty(
		input logic [2:0]        code,
		input logic              alternative_map_select,
		input fps_pkg::fps_src_t s,
		input logic [7:0]        man
	);
		logic [7:0] analog;
		logic [7:0] cpu;
		analog = max2(max2(s.remote1, s.local_t), s.remote2);
		cpu    = max4(s.cpu0, s.cpu1, s.cpu2, s.cpu3);
		pick_duty = fps_pkg::DUTY_FULL;
		if (alternative_map_select) begin
			unique case (code)
				fps_pkg::BHV_SRC0:  pick_duty = s.cpu0;
				fps_pkg::BHV_SRC1:  pick_duty = s.cpu1;
				fps_pkg::BHV_SRC2:  pick_duty = s.cpu2;
				fps_pkg::BHV_SRC3:  pick_duty = s.cpu3;
				fps_pkg::BHV_CODE4: pick_duty = fps_pkg::DUTY_FULL;
				fps_pkg::BHV_CODE5: pick_duty = cpu;
				fps_pkg::BHV_CODE6: pick_duty = fps_pkg::DUTY_FULL;
				fps_pkg::BHV_CODE7: pick_duty = max2(analog, cpu);
			endcase
		end else begin
			unique case (code)
				fps_pkg::BHV_SRC0:  pick_duty = s.remote1;
				fps_pkg::BHV_SRC1:  pick_duty = s.local_t;
				fps_pkg::BHV_SRC2:  pick_duty = s.remote2;
				fps_pkg::BHV_SRC3:  pick_duty = fps_pkg::DUTY_FULL;
				fps_pkg::BHV_CODE4: pick_duty = fps_pkg::DUTY_ZERO;
				fps_pkg::BHV_CODE5: begin
					pick_duty = max2(s.local_t, s.remote2);
				end
				fps_pkg::BHV_CODE6: pick_duty = analog;
				fps_pkg::BHV_CODE7: pick_duty = man;
			endcase
		end
	endfunction

	function automatic logic is_chcfg(input logic [fps_pkg::ADDR_W-1:0] a);
		is_chcfg = (a == fps_pkg::byte_addr(fps_pkg::IDX_CHCFG1))
			|| (a == fps_pkg::byte_addr(fps_pkg::IDX_CHCFG2))
			|| (a == fps_pkg::byte_addr(fps_pkg::IDX_CHCFG3));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// derived channel controls

	logic [fps_pkg::NUM_CH-1:0]      eff_alt;
	logic [fps_pkg::NUM_CH-1:0]      manual;
	logic [fps_pkg::NUM_CH-1:0]      flip;
	logic [fps_pkg::NUM_CH-1:0][2:0] bhv;
	logic                            locked;
	logic                            replace_on;

	assign locked     = st_reg.cfg1[fps_pkg::LOCK_BIT];
	assign replace_on = st_reg.cfg6[fps_pkg::REPL_BIT];

	always_comb begin
		for (int i = 0; i < fps_pkg::NUM_CH; i++) begin
			bhv[i]  = st_reg.chcfg[i][fps_pkg::BHV_MSB:fps_pkg::BHV_LSB];
			flip[i] = st_reg.chcfg[i][fps_pkg::FLIP_BIT];
			eff_alt[i] = st_reg.chcfg[i][fps_pkg::ALT_BIT];
			if (i == 0) begin
				eff_alt[i] = eff_alt[i] | replace_on;
			end
			manual[i] = !eff_alt[i] && (bhv[i] == fps_pkg::BHV_CODE7);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic                       setup_ph;
	logic                       access_ph;
	logic                       wr_en;
	logic [fps_pkg::ADDR_W-1:0] addr;
	logic [7:0]                 wbyte;
	logic [fps_pkg::DATA_W-1:0] rd_val;
	logic                       rd_hit;

	assign setup_ph  = apb_req.psel && !apb_req.penable;
	assign access_ph = apb_req.psel && apb_req.penable;
	assign wr_en     = access_ph && apb_req.pwrite;
	assign addr      = apb_req.paddr;
	assign wbyte     = apb_req.pwdata[7:0];

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		unique case (addr)
			fps_pkg::byte_addr(fps_pkg::IDX_DUTY1):
				rd_val[7:0] = st_reg.man_duty[0];
			fps_pkg::byte_addr(fps_pkg::IDX_DUTY2):
				rd_val[7:0] = st_reg.man_duty[1];
			fps_pkg::byte_addr(fps_pkg::IDX_DUTY3):
				rd_val[7:0] = st_reg.man_duty[2];
			fps_pkg::byte_addr(fps_pkg::IDX_CFG6):
				rd_val[7:0] = st_reg.cfg6;
			fps_pkg::byte_addr(fps_pkg::IDX_CFG1):
				rd_val[7:0] = st_reg.cfg1;
			fps_pkg::byte_addr(fps_pkg::IDX_CHCFG1):
				rd_val[7:0] = st_reg.chcfg[0];
			fps_pkg::byte_addr(fps_pkg::IDX_CHCFG2):
				rd_val[7:0] = st_reg.chcfg[1];
			fps_pkg::byte_addr(fps_pkg::IDX_CHCFG3):
				rd_val[7:0] = st_reg.chcfg[2];
			fps_pkg::byte_addr(fps_pkg::IDX_APPLY1):
				rd_val[7:0] = st_reg.applied[0];
			fps_pkg::byte_addr(fps_pkg::IDX_APPLY2):
				rd_val[7:0] = st_reg.applied[1];
			fps_pkg::byte_addr(fps_pkg::IDX_APPLY3):
				rd_val[7:0] = st_reg.applied[2];
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;

		// read data and error captured in the setup cycle
		if (setup_ph) begin
			st_next.rdata = apb_req.pwrite ? '0 : rd_val;
			st_next.rerr  = !rd_hit;
		end

		if (wr_en && rd_hit) begin
			if (addr == fps_pkg::byte_addr(fps_pkg::IDX_CFG1)) begin
				// lock is sticky until reset
				if (!locked) begin
					st_next.cfg1 = wbyte;
				end
			end
			if (addr == fps_pkg::byte_addr(fps_pkg::IDX_CFG6)) begin
				st_next.cfg6 = wbyte;
			end
			for (int i = 0; i < fps_pkg::NUM_CH; i++) begin
				if (addr == fps_pkg::byte_addr(8'(fps_pkg::IDX_CHCFG1 + i))
					&& !locked) begin
					st_next.chcfg[i] = wbyte;
				end
				if (addr == fps_pkg::byte_addr(8'(fps_pkg::IDX_DUTY1 + i))
					&& manual[i]) begin
					st_next.man_duty[i] = wbyte;
				end
			end
		end

		for (int i = 0; i < fps_pkg::NUM_CH; i++) begin
			st_next.applied[i] = pick_duty(bhv[i], eff_alt[i], src_duty,
				st_reg.man_duty[i]);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg.chcfg    <= {fps_pkg::NUM_CH{fps_pkg::RST_CHCFG}};
			st_reg.man_duty <= {fps_pkg::NUM_CH{fps_pkg::RST_DUTY}};
			st_reg.applied  <= {fps_pkg::NUM_CH{fps_pkg::DUTY_FULL}};
			st_reg.cfg1     <= fps_pkg::RST_CFG1;
			st_reg.cfg6     <= fps_pkg::RST_CFG6;
			st_reg.rdata    <= '0;
			st_reg.rerr     <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer

	logic unused_chcfg;
	assign unused_chcfg = is_chcfg(addr);

	always_comb begin
		apb_rsp.pready  = 1'b1;
		apb_rsp.pslverr = access_ph && st_reg.rerr;
		apb_rsp.prdata  = st_reg.rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// pwm outputs

	for (genvar g = 0; g < fps_pkg::NUM_CH; g++) begin : g_ch
		fps_pwm_gen u_gen (
			.clock (clock),
			.rstn  (rstn),
			.duty  (st_reg.applied[g]),
			.flip  (flip[g]),
			.pwm   (fan_pwm[g])
		);
	end

endmodule
`default_nettype wire

/* inc/fps_pkg.sv */
// Purpose: constants and carriers for the fan channel source select block
// Assumes: APB with 32-bit data, register index times four is the address
// Notes:   printed offsets are register indices, not byte addresses
package fps_pkg;

	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned REG_W   = 8;
	localparam int unsigned NUM_CH  = 3;

	// register indices
	localparam logic [7:0] IDX_DUTY1   = 8'h30;
	localparam logic [7:0] IDX_DUTY2   = 8'h31;
	localparam logic [7:0] IDX_DUTY3   = 8'h32;
	localparam logic [7:0] IDX_CFG6    = 8'h36;
	localparam logic [7:0] IDX_CFG1    = 8'h40;
	localparam logic [7:0] IDX_CHCFG1  = 8'h5C;
	localparam logic [7:0] IDX_CHCFG2  = 8'h5D;
	localparam logic [7:0] IDX_CHCFG3  = 8'h5E;
	localparam logic [7:0] IDX_APPLY1  = 8'h70;
	localparam logic [7:0] IDX_APPLY2  = 8'h71;
	localparam logic [7:0] IDX_APPLY3  = 8'h72;

	// reset values
	localparam logic [7:0] RST_CHCFG   = 8'h62;
	localparam logic [7:0] RST_CFG1    = 8'h00;
	localparam logic [7:0] RST_CFG6    = 8'h00;
	localparam logic [7:0] RST_DUTY    = 8'hFF;

	// field positions
	localparam int unsigned ALT_BIT    = 3;
	localparam int unsigned FLIP_BIT   = 4;
	localparam int unsigned BHV_LSB    = 5;
	localparam int unsigned BHV_MSB    = 7;
	localparam int unsigned LOCK_BIT   = 1;
	localparam int unsigned REPL_BIT   = 4;

	// behaviour codes
	localparam logic [2:0] BHV_SRC0    = 3'h0;
	localparam logic [2:0] BHV_SRC1    = 3'h1;
	localparam logic [2:0] BHV_SRC2    = 3'h2;
	localparam logic [2:0] BHV_SRC3    = 3'h3;
	localparam logic [2:0] BHV_CODE4   = 3'h4;
	localparam logic [2:0] BHV_CODE5   = 3'h5;
	localparam logic [2:0] BHV_CODE6   = 3'h6;
	localparam logic [2:0] BHV_CODE7   = 3'h7;

	// duty figures, full scale is 100%
	localparam logic [7:0] DUTY_FULL   = 8'hFF;
	localparam logic [7:0] DUTY_ZERO   = 8'h00;
	localparam logic [7:0] PWM_TOP     = 8'hFE;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} fps_apb_req_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} fps_apb_rsp_t;

	// computed duties of every temperature source
	typedef struct packed {
		logic [7:0] remote1;
		logic [7:0] local_t;
		logic [7:0] remote2;
		logic [7:0] cpu0;
		logic [7:0] cpu1;
		logic [7:0] cpu2;
		logic [7:0] cpu3;
	} fps_src_t;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
	endfunction

endpackage

/* design/fps_pwm_gen.sv */
// Purpose: one pwm output from a duty value, with polarity flip
// Assumes: duty full scale holds the line active the whole period
// Notes:   period is 255 clocks
`timescale 1ns/1ps
`default_nettype none
module fps_pwm_gen (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [7:0] duty,
	input  wire logic       flip,
	output logic            pwm
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       out;
	} fps_gen_state_t;

	fps_gen_state_t st_reg;
	fps_gen_state_t st_next;

	always_comb begin
		logic active;
		active = 1'b0;
		st_next = st_reg;
		if (st_reg.cnt == fps_pkg::PWM_TOP) begin
			st_next.cnt = fps_pkg::DUTY_ZERO;
		end else begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		active = (st_reg.cnt < duty);
		st_next.out = active ^ flip;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pwm = st_reg.out;

endmodule
`default_nettype wire

/* dv/fps_top_sva.sv */
// Purpose: port checks for the fan channel source select block
// Assumes: channel 1 config mirrored from apb writes
// Notes:   pin follows a config or source change within two clocks
`timescale 1ns/1ps
`default_nettype none
module fps_top_sva (
	input wire logic                         clock,
	input wire logic                         rstn,
	input wire fps_pkg::fps_apb_req_t        apb_req,
	input wire fps_pkg::fps_apb_rsp_t        apb_rsp,
	input wire fps_pkg::fps_src_t            src_duty,
	input wire logic [fps_pkg::NUM_CH-1:0]   fan_pwm
);
	logic [7:0] cfg_reg;
	logic       lock_reg;
	logic       repl_reg;
	wire logic  wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	wire logic [2:0] c = cfg_reg[7:5];
	wire logic  e = cfg_reg[3] || repl_reg;
	wire logic  hi = fan_pwm[0] == !cfg_reg[4];
	wire logic  lo = fan_pwm[0] == cfg_reg[4];
	wire logic  auto_c = e ? !(c == 3'h4 || c == 3'h6) :
		!(c == 3'h3 || c == 3'h4 || c == 3'h7);
	wire logic  s_ff = &src_duty;
	wire logic  s_00 = ~|src_duty;
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_reg  <= fps_pkg::RST_CHCFG;
			lock_reg <= 1'b0;
			repl_reg <= 1'b0;
		end else if (wr && apb_rsp.pready) begin
			if (apb_req.paddr == 12'h170 && !lock_reg)
				cfg_reg <= apb_req.pwdata[7:0];
			if (apb_req.paddr == 12'h100 && !lock_reg)
				lock_reg <= apb_req.pwdata[1];
			if (apb_req.paddr == 12'h0D8)
				repl_reg <= apb_req.pwdata[4];
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	a_full_speed: assert property ((!e && c == 3'h3)[*3] |-> hi)
		else $error("full speed pin wrong");
	a_drive_off: assert property ((!e && c == 3'h4)[*3] |-> lo)
		else $error("disabled pin wrong");
	a_alt_reserved: assert property (
		(e && (c == 3'h4 || c == 3'h6))[*3] |-> hi)
		else $error("reserved code pin wrong");
	a_auto_high: assert property ((auto_c && s_ff)[*3] |-> hi)
		else $error("auto full source pin wrong");
	a_auto_low: assert property ((auto_c && s_00)[*3] |-> lo)
		else $error("auto zero source pin wrong");
	a_pair_max: assert property (
		(!e && c == 3'h5 && src_duty.local_t == 8'hFF)[*3] |-> hi)
		else $error("pair max pin wrong");
	a_analog_max: assert property (
		(!e && c == 3'h6 && src_duty.remote2 == 8'hFF)[*3] |-> hi)
		else $error("analog max pin wrong");
	a_cpu_max: assert property (
		(e && c == 3'h5 && src_duty.cpu2 == 8'hFF)[*3] |-> hi)
		else $error("cpu max pin wrong");
	a_zone_max: assert property (
		(e && c == 3'h7 && src_duty.remote1 == 8'hFF)[*3] |-> hi)
		else $error("zone max pin wrong");
	c_alt_zone: cover property (e && c == 3'h7);
	c_locked: cover property (lock_reg);
	c_flip_off: cover property (cfg_reg[4] && c == 3'h4);
endmodule
bind fps_top fps_top_sva i_fps_top_sva (.clock(clock), .rstn(rstn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .src_duty(src_duty),
	.fan_pwm(fan_pwm));
`default_nettype wire

/* dv/fps_fan_model.sv */
// Purpose: fan stand-in that measures the high time of its drive pin
// Assumes: pwm period of 255 clocks
// Notes:   duty_seen is the high count of the last 255-clock window
`timescale 1ns/1ps
`default_nettype none
module fps_fan_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       pwm,
	output logic [7:0]      duty_seen
);
	logic [7:0] tick_reg;
	logic [7:0] high_reg;
	wire logic  wrap = tick_reg == 8'hFE;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_reg  <= 8'h00;
			high_reg  <= 8'h00;
			duty_seen <= 8'h00;
		end else begin
			tick_reg <= wrap ? 8'h00 : tick_reg + 8'h01;
			high_reg <= wrap ? 8'h00 : high_reg + 8'(pwm);
			if (wrap)
				duty_seen <= high_reg + 8'(pwm);
		end
	end
endmodule
`default_nettype wire

/* dv/fps_top_tb_top.sv */
// Purpose: directed bench for the fan channel source select block
// Assumes: zero-wait apb slave, applied duty readable at index 0x70
// Notes:   one task per scenario, lock runs last as it is sticky
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		err_count++; \
		$display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
	end \
end
module fps_top_tb_top;
	logic                  clock;
	logic                  rstn;
	fps_pkg::fps_apb_req_t req;
	fps_pkg::fps_apb_rsp_t rsp;
	fps_pkg::fps_src_t     src;
	logic [2:0]            pwm;
	logic [7:0]            seen;
	logic [7:0]            seen2;
	logic [7:0]            seen3;
	logic [7:0]            rd;
	logic                  serr;
	int                    err_count;
	int                    check_count;
	logic [7:0]            exp_d [16] = '{8'hB0, 8'h90, 8'h33, 8'hFF,
		8'h00, 8'h90, 8'hB0, 8'hFF, 8'h44, 8'hA5, 8'h26, 8'h37,
		8'hFF, 8'hA5, 8'hFF, 8'hB0};
	fps_top i_fps_top (.clock(clock), .rstn(rstn), .apb_req(req),
		.apb_rsp(rsp), .src_duty(src), .fan_pwm(pwm));
	fps_fan_model i_fps_fan_model (.clock(clock), .rstn(rstn),
		.pwm(pwm[0]), .duty_seen(seen));
	fps_fan_model i_fps_fan_model_2 (.clock(clock), .rstn(rstn),
		.pwm(pwm[1]), .duty_seen(seen2));
	fps_fan_model i_fps_fan_model_3 (.clock(clock), .rstn(rstn),
		.pwm(pwm[2]), .duty_seen(seen3));
	////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, {2'b00, a, 2'b00}, {24'h00_0000, d}};
		@(posedge clock);
		req.penable <= 1'b1;
		do @(posedge clock); while (rsp.pready !== 1'b1);
		rd = rsp.prdata[7:0];
		serr = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [7:0] ex);
		xfer(1'b0, a, 8'h00);
		`CHK(nm, ex, rd)
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 3; i++)
			rchk("chcfg", 8'h5C + i[7:0], fps_pkg::RST_CHCFG);
		rchk("applied", 8'h70, 8'hFF);
		xfer(1'b0, 8'h01, 8'h00);
		`CHK("unmapped", 1'b1, serr)
	endtask
	task automatic t_map();
		src <= '{8'hB0, 8'h90, 8'h33, 8'h44, 8'hA5, 8'h26, 8'h37};
		for (int i = 0; i < 16; i++) begin
			xfer(1'b1, 8'h5C, {i[2:0], 1'b0, i[3], 3'h2});
			rchk("map", 8'h70, exp_d[i]);
		end
	endtask
	task automatic t_manual();
		xfer(1'b1, 8'h5C, 8'hE2);
		xfer(1'b1, 8'h30, 8'h5A);
		rchk("manual", 8'h70, 8'h5A);
		xfer(1'b1, 8'h5C, 8'h62);
		xfer(1'b1, 8'h30, 8'h22);
		rchk("duty kept", 8'h30, 8'h5A);
	endtask
	task automatic t_pwm();
		src.remote1 <= 8'h40;
		xfer(1'b1, 8'h5C, 8'h02);
		repeat (520) @(posedge clock);
		`CHK("high count", 8'h40, seen)
		`CHK("ch2 count", 8'hFF, seen2)
		`CHK("ch3 count", 8'hFF, seen3)
		xfer(1'b1, 8'h5C, 8'h12);
		repeat (520) @(posedge clock);
		`CHK("flip count", 8'hBF, seen)
	endtask
	task automatic t_replace();
		xfer(1'b1, 8'h36, 8'h10);
		xfer(1'b1, 8'h5D, 8'h02);
		rchk("repl map", 8'h70, 8'h44);
		rchk("repl bit", 8'h5C, 8'h12);
		rchk("ch2 map", 8'h71, 8'h40);
		xfer(1'b1, 8'h36, 8'h00);
	endtask
	task automatic t_extreme();
		for (int i = 0; i < 32; i++) begin
			xfer(1'b1, 8'h5C, {i[2:0], i[4], i[3], 3'h2});
			src <= '1;
			repeat (4) @(posedge clock);
			src <= '0;
			repeat (4) @(posedge clock);
		end
	endtask
	task automatic t_lock();
		xfer(1'b1, 8'h5C, 8'h62);
		xfer(1'b1, 8'h40, 8'h02);
		xfer(1'b1, 8'h5C, 8'h8A);
		rchk("locked cfg", 8'h5C, 8'h62);
		rchk("locked out", 8'h70, 8'hFF);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		#40000;
		err_count++;
		print_verdict();
	end
	initial begin
		rstn = 1'b0;
		req = '0;
		src = '0;
		err_count = 0;
		check_count = 0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_map();
		t_manual();
		t_pwm();
		t_replace();
		t_extreme();
		t_lock();
		print_verdict();
	end
endmodule
`default_nettype wire
